/* File: verilog/sd_pkg.sv */
// Constants, field layout and carrier types of the silent decay configuration bank
package sd_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h31;
  localparam logic [7:0] ADDR_PROP_GAIN = 8'h32;
  localparam logic [7:0] ADDR_INTEG_GAIN = 8'h33;
  localparam logic [7:0] ADDR_GAIN_DIVS = 8'h34;
  localparam logic [7:0] ADDR_EXIT_THR  = 8'h35;

  localparam logic [7:0] RST_CTRL_ONE   = 8'h00;
  localparam logic [7:0] RST_PROP_GAIN  = 8'h00;
  localparam logic [7:0] RST_INTEG_GAIN = 8'h00;
  localparam logic [7:0] RST_GAIN_DIVS  = 8'h00;
  localparam logic [7:0] RST_EXIT_THR   = 8'hFF;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int EN_BIT      = 0;
  localparam int PWM_LSB     = 2;
  localparam int SMPL_LSB    = 6;
  localparam int GAIN_LSB    = 0;
  localparam int GAIN_W      = 7;
  localparam int KP_DIV_LSB  = 0;
  localparam int KI_DIV_LSB  = 4;
  localparam int DIV_W       = 3;
  localparam int GAIN_FRAC_W = 9;
  localparam int EFF_W       = GAIN_W + GAIN_FRAC_W;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ         = 50_000_000;
  localparam int SMPL_US_CODE0  = 2;
  localparam int SMPL_US_CODE1  = 3;
  localparam int SMPL_US_CODE2  = 4;
  localparam int SMPL_CYC_CODE0 = (CLK_HZ / 1_000_000) * SMPL_US_CODE0;
  localparam int SMPL_CYC_CODE1 = (CLK_HZ / 1_000_000) * SMPL_US_CODE1;
  localparam int SMPL_CYC_CODE2 = (CLK_HZ / 1_000_000) * SMPL_US_CODE2;
  localparam int SMPL_CNT_W     = 8;

  localparam int PWM_KHZ_CODE0 = 25;
  localparam int PWM_KHZ_CODE1 = 33;
  localparam int PWM_KHZ_CODE2 = 42;
  localparam int PWM_KHZ_CODE3 = 50;
  localparam int PWM_CYC_CODE0 = CLK_HZ / (PWM_KHZ_CODE0 * 1000);
  localparam int PWM_CYC_CODE1 = CLK_HZ / (PWM_KHZ_CODE1 * 1000);
  localparam int PWM_CYC_CODE2 = CLK_HZ / (PWM_KHZ_CODE2 * 1000);
  localparam int PWM_CYC_CODE3 = CLK_HZ / (PWM_KHZ_CODE3 * 1000);
  localparam int PWM_CNT_W     = 11;

  localparam int THR_HZ_PER_LSB = 2;
  localparam int FREQ_W         = 10;

  // Divider codes as right shift amounts
  localparam logic [3:0] SHIFT_CODE0 = 4'h5;
  localparam logic [3:0] SHIFT_CODE1 = 4'h6;
  localparam logic [3:0] SHIFT_CODE2 = 4'h7;
  localparam logic [3:0] SHIFT_CODE3 = 4'h8;
  localparam logic [3:0] SHIFT_CODE4 = 4'h9;
  localparam logic [3:0] SHIFT_DIV16 = 4'h4;
  localparam logic [3:0] SHIFT_NONE  = 4'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sd_bus_req_t;

  typedef struct packed {
    logic [EFF_W-1:0] kp_eff;
    logic [EFF_W-1:0] ki_eff;
  } sd_gains_t;

endpackage

/* File: verilog/sd_pwm_timer.sv */
// PWM period tick generator for the silent decay mode
`timescale 1ns/1ps
module sd_pwm_timer #(
  parameter int CNT_W = 11
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] period,
  output logic                  tick_q
);

  logic [CNT_W-1:0] cnt_q;

  // Period taken at each tick, so a rate change lands on a period boundary
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !run) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q  <= period - CNT_W'(1);
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q - CNT_W'(1);
      tick_q <= 1'b0;
    end
  end

endmodule // sd_pwm_timer

/* File: verilog/sd_config_bank.sv */
// Silent decay configuration bank: registers, gain scaling, mode and timing
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps

module sd_config_bank (
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  input  wire sd_pkg::sd_bus_req_t        bus_req,
  output logic [sd_pkg::DATA_W-1:0]       rd_data_q,
  input  wire logic [sd_pkg::FREQ_W-1:0]  sine_freq_hz,
  input  wire logic                       zero_cross,
  output logic                            mode_active_q,
  output logic                            sample_active_q,
  output logic                            pwm_tick,
  output sd_pkg::sd_gains_t               gains_q
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [sd_pkg::DATA_W-1:0] ctrl_one_q;
  logic [sd_pkg::DATA_W-1:0] prop_gain_q;
  logic [sd_pkg::DATA_W-1:0] integ_gain_q;
  logic [sd_pkg::DATA_W-1:0] gain_divs_q;
  logic [sd_pkg::DATA_W-1:0] exit_thr_q;

  logic wr_ctrl;
  logic wr_prop;
  logic wr_integ;
  logic wr_divs;
  logic wr_thr;

  assign wr_ctrl  = bus_req.wr && (bus_req.addr == sd_pkg::ADDR_CTRL_ONE);
  assign wr_prop  = bus_req.wr && (bus_req.addr == sd_pkg::ADDR_PROP_GAIN);
  assign wr_integ = bus_req.wr && (bus_req.addr == sd_pkg::ADDR_INTEG_GAIN);
  assign wr_divs  = bus_req.wr && (bus_req.addr == sd_pkg::ADDR_GAIN_DIVS);
  assign wr_thr   = bus_req.wr && (bus_req.addr == sd_pkg::ADDR_EXIT_THR);

  // Reserved bits are plain storage and read back as written
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_one_q <= sd_pkg::RST_CTRL_ONE;
    end else if (wr_ctrl) begin
      ctrl_one_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prop_gain_q  <= sd_pkg::RST_PROP_GAIN;
      integ_gain_q <= sd_pkg::RST_INTEG_GAIN;
    end else begin
      if (wr_prop) begin
        prop_gain_q <= bus_req.wdata;
      end
      if (wr_integ) begin
        integ_gain_q <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gain_divs_q <= sd_pkg::RST_GAIN_DIVS;
    end else if (wr_divs) begin
      gain_divs_q <= bus_req.wdata;
    end
  end

  // A zero threshold would pin the mode off; such a write is dropped
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      exit_thr_q <= sd_pkg::RST_EXIT_THR;
    end else if (wr_thr && (bus_req.wdata != 8'h00)) begin
      exit_thr_q <= bus_req.wdata;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_data_q <= sd_pkg::RD_UNMAPPED;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        sd_pkg::ADDR_CTRL_ONE:   rd_data_q <= ctrl_one_q;
        sd_pkg::ADDR_PROP_GAIN:  rd_data_q <= prop_gain_q;
        sd_pkg::ADDR_INTEG_GAIN: rd_data_q <= integ_gain_q;
        sd_pkg::ADDR_GAIN_DIVS:  rd_data_q <= gain_divs_q;
        sd_pkg::ADDR_EXIT_THR:   rd_data_q <= exit_thr_q;
        default:                 rd_data_q <= sd_pkg::RD_UNMAPPED;
      endcase
    end else begin
      rd_data_q <= sd_pkg::RD_UNMAPPED;
    end
  end

  // ****************************************************************
  // Effective gains
  // ****************************************************************
  // Unlisted code 7 is taken as the reset divider
  function automatic logic [3:0] div_shift(input logic [2:0] code, input logic integ);
    logic [3:0] s;
    s = sd_pkg::SHIFT_CODE0;
    case (code)
      3'h0:    s = sd_pkg::SHIFT_CODE0;
      3'h1:    s = sd_pkg::SHIFT_CODE1;
      3'h2:    s = sd_pkg::SHIFT_CODE2;
      3'h3:    s = sd_pkg::SHIFT_CODE3;
      3'h4:    s = sd_pkg::SHIFT_CODE4;
      3'h5:    s = sd_pkg::SHIFT_DIV16;
      3'h6:    s = integ ? sd_pkg::SHIFT_NONE : sd_pkg::SHIFT_DIV16;
      default: s = sd_pkg::SHIFT_CODE0;
    endcase
    return s;
  endfunction

  logic [sd_pkg::GAIN_W-1:0] raw_prop_gain;
  logic [sd_pkg::GAIN_W-1:0] raw_integ_gain;
  logic [sd_pkg::DIV_W-1:0]  prop_gain_divider;
  logic [sd_pkg::DIV_W-1:0]  integ_gain_divider;

  assign raw_prop_gain      = prop_gain_q[sd_pkg::GAIN_LSB +: sd_pkg::GAIN_W];
  assign raw_integ_gain     = integ_gain_q[sd_pkg::GAIN_LSB +: sd_pkg::GAIN_W];
  assign prop_gain_divider  = gain_divs_q[sd_pkg::KP_DIV_LSB +: sd_pkg::DIV_W];
  assign integ_gain_divider = gain_divs_q[sd_pkg::KI_DIV_LSB +: sd_pkg::DIV_W];

  // Fraction bits kept so that small gains survive the divide
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gains_q <= '0;
    end else begin
      gains_q.kp_eff <= sd_pkg::EFF_W'({raw_prop_gain, {sd_pkg::GAIN_FRAC_W{1'b0}}}
                        >> div_shift(prop_gain_divider, 1'b0));
      gains_q.ki_eff <= sd_pkg::EFF_W'({raw_integ_gain, {sd_pkg::GAIN_FRAC_W{1'b0}}}
                        >> div_shift(integ_gain_divider, 1'b1));
    end
  end

  // ****************************************************************
  // Mode control
  // ****************************************************************
  logic                      mode_enable;
  logic [sd_pkg::FREQ_W-1:0] exit_freq_hz;

  assign mode_enable  = ctrl_one_q[sd_pkg::EN_BIT];
  assign exit_freq_hz = sd_pkg::FREQ_W'(exit_thr_q * sd_pkg::THR_HZ_PER_LSB);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode_active_q <= 1'b0;
    end else begin
      mode_active_q <= mode_enable && (sine_freq_hz <= exit_freq_hz);
    end
  end

  // ****************************************************************
  // PWM rate
  // ****************************************************************
  logic [sd_pkg::PWM_CNT_W-1:0] pwm_cycles;

  always_comb begin
    case (ctrl_one_q[sd_pkg::PWM_LSB +: 2])
      2'h0:    pwm_cycles = sd_pkg::PWM_CNT_W'(sd_pkg::PWM_CYC_CODE0);
      2'h1:    pwm_cycles = sd_pkg::PWM_CNT_W'(sd_pkg::PWM_CYC_CODE1);
      2'h2:    pwm_cycles = sd_pkg::PWM_CNT_W'(sd_pkg::PWM_CYC_CODE2);
      default: pwm_cycles = sd_pkg::PWM_CNT_W'(sd_pkg::PWM_CYC_CODE3);
    endcase
  end

  sd_pwm_timer #(
    .CNT_W (sd_pkg::PWM_CNT_W)
  ) u_pwm_timer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .run     (mode_active_q),
    .period  (pwm_cycles),
    .tick_q  (pwm_tick)
  );

  // ****************************************************************
  // Zero-cross sample window
  // ****************************************************************
  logic [sd_pkg::SMPL_CNT_W-1:0] smpl_cycles;
  logic [sd_pkg::SMPL_CNT_W-1:0] smpl_cnt_q;
  logic                          smpl_load;

  // Unlisted code 11 falls back to the longest window
  always_comb begin
    case (ctrl_one_q[sd_pkg::SMPL_LSB +: 2])
      2'h0:    smpl_cycles = sd_pkg::SMPL_CNT_W'(sd_pkg::SMPL_CYC_CODE0);
      2'h1:    smpl_cycles = sd_pkg::SMPL_CNT_W'(sd_pkg::SMPL_CYC_CODE1);
      default: smpl_cycles = sd_pkg::SMPL_CNT_W'(sd_pkg::SMPL_CYC_CODE2);
    endcase
  end

  // A crossing during an open window is ignored, not restarted
  assign smpl_load = zero_cross && mode_active_q && (smpl_cnt_q == '0);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      smpl_cnt_q      <= '0;
      sample_active_q <= 1'b0;
    end else if (smpl_load) begin
      smpl_cnt_q      <= smpl_cycles;
      sample_active_q <= 1'b1;
    end else if (smpl_cnt_q != '0) begin
      smpl_cnt_q      <= smpl_cnt_q - sd_pkg::SMPL_CNT_W'(1);
      sample_active_q <= (smpl_cnt_q != sd_pkg::SMPL_CNT_W'(1));
    end
  end

  // ****************************************************************
  // Assertion helpers
  // ****************************************************************
  logic [sd_pkg::SMPL_CNT_W-1:0] smpl_len_q;
  logic [sd_pkg::SMPL_CNT_W-1:0] smpl_exp_q;
  logic [sd_pkg::PWM_CNT_W-1:0]  pwm_prev_q;
  logic [sd_pkg::PWM_CNT_W-1:0]  pwm_exp_q;
  logic [sd_pkg::PWM_CNT_W-1:0]  pwm_gap_q;
  logic                          pwm_seen_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      smpl_len_q <= '0;
      smpl_exp_q <= '0;
    end else if (smpl_load) begin
      smpl_len_q <= sd_pkg::SMPL_CNT_W'(1);
      smpl_exp_q <= smpl_cycles;
    end else if (sample_active_q) begin
      smpl_len_q <= smpl_len_q + sd_pkg::SMPL_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || !mode_active_q) begin
      pwm_prev_q <= '0;
      pwm_exp_q  <= '0;
      pwm_gap_q  <= '0;
      pwm_seen_q <= 1'b0;
    end else begin
      pwm_prev_q <= pwm_cycles;
      pwm_gap_q  <= pwm_tick ? sd_pkg::PWM_CNT_W'(1) : pwm_gap_q + sd_pkg::PWM_CNT_W'(1);
      if (pwm_tick) begin
        pwm_exp_q  <= pwm_prev_q;
        pwm_seen_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_mode_needs_enable: assert property (!$past(mode_enable) |-> !mode_active_q)
    else $error("mode active without enable");

  a_sample_window_len: assert property (sample_active_q && smpl_cnt_q == 8'h01 |-> smpl_len_q == smpl_exp_q)
    else $error("sample window length wrong");

  a_pwm_period_gap: assert property (pwm_tick && pwm_seen_q && mode_active_q |-> pwm_gap_q == pwm_exp_q)
    else $error("pwm period wrong");

  a_prop_gain_store: assert property (wr_prop |=> raw_prop_gain == $past(bus_req.wdata[6:0]))
    else $error("prop gain not stored");

  a_integ_gain_store: assert property (wr_integ |=> ##1 ($past(integ_gain_divider) != 3'h6
    || gains_q.ki_eff[15:9] == $past(bus_req.wdata[6:0], 2)))
    else $error("integ gain not stored");

  a_integ_no_divide: assert property ($past(integ_gain_divider) == 3'h6 |-> gains_q.ki_eff
    == {$past(raw_integ_gain), 9'h000})
    else $error("integ undivided gain wrong");

  a_prop_div_sixteen: assert property ($past(prop_gain_divider) == 3'h6 |-> gains_q.kp_eff
    == {4'h0, $past(raw_prop_gain), 5'h00})
    else $error("prop divide by sixteen wrong");

  a_unmapped_reads_zero: assert property (bus_req.rd
    && (bus_req.addr < sd_pkg::ADDR_CTRL_ONE || bus_req.addr > sd_pkg::ADDR_EXIT_THR)
    |=> rd_data_q == 8'h00)
    else $error("unmapped read not zero");

  a_exit_above_thr: assert property ($past(sine_freq_hz) > $past(exit_freq_hz) |-> !mode_active_q)
    else $error("mode held above exit frequency");

  a_prop_div_default: assert property ($past(prop_gain_divider) == 3'h0 |-> gains_q.kp_eff
    == {5'h00, $past(raw_prop_gain), 4'h0})
    else $error("prop gain shift wrong");

  c_mode_on: cover property (!mode_active_q ##1 mode_active_q);
  c_window_done: cover property ($fell(sample_active_q));
  c_two_ticks: cover property (pwm_tick && pwm_seen_q);
  c_exit_freq: cover property (mode_active_q ##1 !mode_active_q && mode_enable);

endmodule // sd_config_bank

/* File: verif/sd_config_bank_bench.sv */
// Self-checking bench for the silent decay configuration bank
`timescale 1ns/1ps
module sd_config_bank_bench;
  // ****************************************************************
  // Signals and instance
  // ****************************************************************
  logic                       sys_clk;
  logic                       reset_n;
  sd_pkg::sd_bus_req_t        bus_req;
  logic [sd_pkg::DATA_W-1:0]  rd_data_q;
  logic [sd_pkg::FREQ_W-1:0]  sine_freq_hz;
  logic                       zero_cross;
  logic                       mode_active_q;
  logic                       sample_active_q;
  logic                       pwm_tick;
  sd_pkg::sd_gains_t          gains_q;
  int                         errors;
  int                         cmp_count;

  sd_config_bank uut (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .bus_req         (bus_req),
    .rd_data_q       (rd_data_q),
    .sine_freq_hz    (sine_freq_hz),
    .zero_cross      (zero_cross),
    .mode_active_q   (mode_active_q),
    .sample_active_q (sample_active_q),
    .pwm_tick        (pwm_tick),
    .gains_q         (gains_q)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Expectations, comparison and bus tasks
  // ****************************************************************
  function automatic logic [15:0] eff_gain(input logic [6:0] raw, input logic [2:0] code, input bit integ);
    logic [3:0] s;
    case (code)
      3'h0: s = 4'h5;
      3'h1: s = 4'h6;
      3'h2: s = 4'h7;
      3'h3: s = 4'h8;
      3'h4: s = 4'h9;
      3'h5: s = 4'h4;
      3'h6: s = integ ? 4'h0 : 4'h4;
      default: s = 4'h5;
    endcase
    return {raw, 9'h000} >> s;
  endfunction

  function automatic int pwm_period(input logic [1:0] code);
    int tbl[4] = '{2000, 1515, 1190, 1000};
    return tbl[code];
  endfunction

  function automatic int smpl_len(input logic [1:0] code);
    int tbl[4] = '{100, 150, 200, 200};
    return tbl[code];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    bus_req.wr    <= 1'b1;
    bus_req.addr  <= addr;
    bus_req.wdata <= data;
    @(posedge sys_clk);
    bus_req.wr    <= 1'b0;
    bus_req.wdata <= ~data;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= addr;
    @(posedge sys_clk);
    bus_req.rd   <= 1'b0;
    #1 data = rd_data_q;
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(addr, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  // Bounded wait; returns 3000 when no tick came
  task automatic wait_tick(output int cyc);
    cyc = 0;
    do begin
      @(posedge sys_clk);
      #1 cyc++;
    end while (pwm_tick !== 1'b1 && cyc < 3000);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(20 * 60000);
    errors++;
    conclude();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [7:0] v;
    logic [7:0] kp;
    logic [7:0] ki;
    int n;
    errors = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    bus_req = '0;
    sine_freq_hz = '0;
    zero_cross = 1'b0;
    void'($urandom(32'h7f622f69));
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1 check({15'h0000, mode_active_q}, 16'h0000);
    check(gains_q.kp_eff, 16'h0000);
    check(gains_q.ki_eff, 16'h0000);
    // Reset values, then unlisted offsets, read but never written
    rd_check(8'h31, 8'h00);
    @(posedge sys_clk);
    #1 check({8'h00, rd_data_q}, 16'h0000);
    rd_check(8'h32, 8'h00);
    rd_check(8'h33, 8'h00);
    rd_check(8'h34, 8'h00);
    rd_check(8'h35, 8'hFF);
    rd_check(8'h2F, 8'h00);
    rd_check(8'hFF, 8'h00);
    rd_check(8'h30, 8'h00);
    rd_check(8'h36, 8'h00);
    rd_check(8'h31, 8'h00);
    // Gains over every divider code, full-byte readback
    for (int c = 0; c < 8; c++) begin
      kp = (c == 0) ? 8'hFF : 8'($urandom);
      ki = (c == 7) ? 8'h7F : 8'($urandom);
      wr_reg(8'h32, kp);
      wr_reg(8'h33, ki);
      wr_reg(8'h34, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
      @(posedge sys_clk);
      #1 check(gains_q.kp_eff, eff_gain(kp[6:0], 3'(c), 1'b0));
      check(gains_q.ki_eff, eff_gain(ki[6:0], 3'(7 - c), 1'b1));
      rd_check(8'h32, kp);
      rd_check(8'h33, ki);
    end
    // Exit threshold: host never writes zero; compare with twice the code
    wr_reg(8'h35, 8'h01);
    wr_reg(8'h35, 8'h0A);
    rd_check(8'h35, 8'h0A);
    wr_reg(8'h31, 8'h01);
    for (int i = 0; i < 24; i++) begin
      v = (i < 2) ? 8'h0A : 8'(($urandom % 255) + 1);
      if (i >= 2) wr_reg(8'h35, v);
      @(posedge sys_clk);
      sine_freq_hz <= (i == 0) ? 10'd20 : (i == 1) ? 10'd21 : 10'($urandom % 600);
      repeat (2) @(posedge sys_clk);
      #1 check({15'h0000, mode_active_q}, {15'h0000, (sine_freq_hz <= 2 * v)});
    end
    @(posedge sys_clk);
    // Lowest possible exit frequency, so the mode stays on whatever code came last
    sine_freq_hz <= 10'd2;
    // PWM period for each rate code, sample window for each time code
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h31, {2'(c), 2'b00, 2'(c), 1'b0, 1'b1});
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      check(16'(n), 16'(pwm_period(2'(c))));
      @(posedge sys_clk);
      zero_cross <= 1'b1;
      @(posedge sys_clk);
      zero_cross <= 1'b0;
      n = 0;
      #1 while (sample_active_q === 1'b1 && n < 400) begin
        n++;
        @(posedge sys_clk);
        #1;
      end
      check(16'(n), 16'(smpl_len(2'(c))));
    end
    // Disabled mode: no ticks, zero crossings ignored
    wr_reg(8'h31, 8'h0C);
    repeat (2) @(posedge sys_clk);
    #1 check({15'h0000, mode_active_q}, 16'h0000);
    @(posedge sys_clk);
    zero_cross <= 1'b1;
    @(posedge sys_clk);
    zero_cross <= 1'b0;
    #1 check({15'h0000, sample_active_q}, 16'h0000);
    wait_tick(n);
    check(16'(n), 16'd3000);
    conclude();
  end
endmodule // sd_config_bank_bench
